// file: rtl/dmr_mode_regs.sv
// Mode registers for max-activate, row refresh, repair, calibration pattern A and ECC
// Assumes commands arrive pre-decoded and one beat of calibration data leaves per clock
`timescale 1ns/1ps
module dmr_mode_regs #(
   parameter int BANKS = 8,
   parameter logic [2:0] MAC_CODE = 3'h1,
   parameter bit MAC_UNLIMITED = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire dmr_pkg::dmr_cmd_s i_cmd,
   input wire logic [BANKS-1:0] i_repair_avail,
   input wire logic [7:0] i_pattern_b,
   input wire logic [7:0] i_invert_lower,
   input wire logic [7:0] i_invert_upper,
   input wire logic i_bus_inv_read_en,
   input wire logic i_ecc_event,
   input wire logic i_ecc_double,
   output logic [7:0] o_read_data,
   output logic o_read_valid,
   output dmr_pkg::dmr_beat_s o_cal_beat,
   output logic o_cal_valid,
   output logic o_correction_enable,
   output logic o_targeted_row_refresh,
   output logic [2:0] o_target_bank_select,
   output logic o_err_pad
);
   // Refused at elaboration: the register layout fixes both of these
   if (BANKS != 8) begin : g_bad_banks
      $error("Repair register maps exactly eight banks");
   end
   if (MAC_CODE == dmr_pkg::MAC_RESERVED) begin : g_bad_mac
      $error("Reserved max-activate code");
   end

   typedef enum logic [1:0] {
      DMR_IDLE = 2'b01,
      DMR_SEND = 2'b10
   } dmr_state_e;

   logic [7:0] pattern_a;
   logic trr_en;
   logic [2:0] trr_bank;
   logic ecc_on;
   logic err_pin_en;
   logic flag_double;
   logic flag_event;
   logic [7:0] event_count;
   logic [15:0] cal_stream;
   logic [4:0] bit_idx;
   dmr_state_e state;
   logic cal_start;
   logic record_clear;
   logic cal_bit;

   function automatic logic wr_to(input dmr_pkg::dmr_cmd_s c, input logic [5:0] a);
      return c.mode_register_write && (c.addr == a);
   endfunction

   assign cal_start = i_cmd.multipurpose_command && (i_cmd.op[6:0] == dmr_pkg::OPC_READ_CAL);
   // Pulse only; the bit is never stored, so it reads back as zero
   assign record_clear = wr_to(i_cmd, dmr_pkg::ADDR_ECC_CTL) && i_cmd.op[dmr_pkg::BIT_REC_CLR];
   assign cal_bit = cal_stream[bit_idx[3:0]];

   // Test register 1E decodes to nothing on purpose
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pattern_a <= dmr_pkg::PAT_A_RESET;
      end else if (wr_to(i_cmd, dmr_pkg::ADDR_PAT_A)) begin
         pattern_a <= i_cmd.op;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         trr_en <= 1'b0;
         trr_bank <= 3'h0;
      end else if (wr_to(i_cmd, dmr_pkg::ADDR_ACT_TRR)) begin
         trr_en <= i_cmd.op[dmr_pkg::BIT_TRR_EN];
         trr_bank <= i_cmd.op[dmr_pkg::BIT_TRR_BANK_HI:dmr_pkg::BIT_TRR_BANK_LO];
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ecc_on <= 1'b1;
         err_pin_en <= 1'b0;
      end else if (wr_to(i_cmd, dmr_pkg::ADDR_ECC_CTL)) begin
         ecc_on <= i_cmd.op[dmr_pkg::BIT_ECC_ON];
         err_pin_en <= i_cmd.op[dmr_pkg::BIT_ERR_PIN];
      end
   end

   // Detection beats the clear in the same cycle so no event is lost
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         flag_double <= 1'b0;
         flag_event <= 1'b0;
      end else begin
         if (ecc_on && i_ecc_double) begin
            flag_double <= 1'b1;
         end else if (record_clear) begin
            flag_double <= 1'b0;
         end
         if (ecc_on && i_ecc_event) begin
            flag_event <= 1'b1;
         end else if (record_clear) begin
            flag_event <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         event_count <= 8'h00;
      end else if (ecc_on && i_ecc_event) begin
         if (record_clear) begin
            event_count <= 8'h01;
         end else if (event_count != dmr_pkg::CNT_MAX) begin
            event_count <= event_count + 8'h01;
         end
      end else if (record_clear) begin
         event_count <= 8'h00;
      end
   end

   // Mode-register read answers the next cycle; write-only fields read zero
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_read_data <= 8'h00;
         o_read_valid <= 1'b0;
      end else begin
         o_read_valid <= i_cmd.mrr;
         o_read_data <= 8'h00;
         if (i_cmd.mrr) begin
            case (i_cmd.addr)
               dmr_pkg::ADDR_ACT_TRR: begin
                  o_read_data[dmr_pkg::BIT_UNLIMITED] <= MAC_UNLIMITED;
                  o_read_data[2:0] <= MAC_UNLIMITED ? dmr_pkg::MAC_UNKNOWN : MAC_CODE;
               end
               dmr_pkg::ADDR_REPAIR: o_read_data <= i_repair_avail;
               dmr_pkg::ADDR_ECC_CTL: begin
                  o_read_data[dmr_pkg::BIT_ECC_ON] <= ecc_on;
                  o_read_data[dmr_pkg::BIT_ERR_PIN] <= err_pin_en;
                  o_read_data[dmr_pkg::BIT_DOUBLE] <= flag_double;
                  o_read_data[dmr_pkg::BIT_EVENT] <= flag_event;
               end
               dmr_pkg::ADDR_ECC_CNT: o_read_data <= event_count;
               default: o_read_data <= 8'h00;
            endcase
         end
      end
   end

   // Pattern A then B, low-order bit first
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= DMR_IDLE;
         cal_stream <= 16'h0000;
         bit_idx <= 5'h00;
      end else begin
         case (state)
            DMR_IDLE: begin
               if (cal_start) begin
                  cal_stream <= {i_pattern_b, pattern_a};
                  bit_idx <= 5'h00;
                  state <= DMR_SEND;
               end
            end
            DMR_SEND: begin
               if (bit_idx == 5'(dmr_pkg::BURST_BITS - 1)) begin
                  state <= DMR_IDLE;
               end
               bit_idx <= bit_idx + 5'h01;
            end
            default: state <= DMR_IDLE;
         endcase
      end
   end

   // Bus-inversion enable deliberately unused here: calibration return is never encoded
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_cal_beat <= '0;
         o_cal_valid <= 1'b0;
      end else begin
         o_cal_valid <= (state == DMR_SEND);
         if (state == DMR_SEND) begin
            o_cal_beat.dq <= {16{cal_bit}} ^ {i_invert_upper, i_invert_lower};
            o_cal_beat.data_mask_inversion_pin <= {2{cal_bit}};
         end else begin
            o_cal_beat <= '0;
         end
      end
   end

   assign o_correction_enable = ecc_on;
   assign o_targeted_row_refresh = trr_en;
   assign o_target_bank_select = trr_bank;
   assign o_err_pad = ecc_on && err_pin_en && (flag_event || flag_double);

   a_err_pad_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_err_pad |-> (ecc_on && err_pin_en))
      else $error("Error pad driven while gated off");
   a_clear_flags: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (record_clear && !i_ecc_event && !i_ecc_double) |=> (!flag_event && !flag_double
      && event_count == 8'h00))
      else $error("Record clear left state behind");
   a_flag_sticky: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (flag_event && !record_clear) |=> flag_event)
      else $error("Event flag dropped without clear");
   a_count_step: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (ecc_on && i_ecc_event && !record_clear && event_count != dmr_pkg::CNT_MAX)
      |=> event_count == $past(event_count) + 8'h01)
      else $error("Event counter did not step");
   a_count_sat: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (event_count == dmr_pkg::CNT_MAX && !record_clear) |=> event_count == dmr_pkg::CNT_MAX)
      else $error("Event counter wrapped");
   a_pat_a_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      wr_to(i_cmd, dmr_pkg::ADDR_PAT_A) |=> pattern_a == $past(i_cmd.op))
      else $error("Pattern A not loaded");
   a_cal_length: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state == DMR_IDLE && cal_start) |=> ##1 o_cal_valid [*8] ##1 o_cal_valid [*8]
      ##1 !o_cal_valid)
      else $error("Calibration burst length wrong");
   a_dmi_true: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_cal_valid |-> (o_cal_beat.data_mask_inversion_pin == {2{$past(cal_bit)}}))
      else $error("Mask pin data not true pattern");
   a_mac_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_cmd.mrr && i_cmd.addr == dmr_pkg::ADDR_ACT_TRR) |=>
      (o_read_data[dmr_pkg::BIT_UNLIMITED] == MAC_UNLIMITED
      && (!o_read_data[dmr_pkg::BIT_UNLIMITED] || o_read_data[2:0] == dmr_pkg::MAC_UNKNOWN)))
      else $error("Max-activate field nonzero when unlimited");

   // Read path: layout of each answer and the fields that never show
   a_mac_reserved: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_cmd.mrr && i_cmd.addr == dmr_pkg::ADDR_ACT_TRR)
      |=> (o_read_valid && o_read_data[2:0] != dmr_pkg::MAC_RESERVED))
      else $error("Reserved max-activate code read back");
   a_trr_write_only: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_cmd.mrr && i_cmd.addr == dmr_pkg::ADDR_ACT_TRR)
      |=> o_read_data[dmr_pkg::BIT_TRR_EN:dmr_pkg::BIT_TRR_BANK_LO] == 4'h0)
      else $error("Row-refresh settings visible on read");
   a_repair_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_cmd.mrr && i_cmd.addr == dmr_pkg::ADDR_REPAIR)
      |=> (o_read_valid && o_read_data == $past(i_repair_avail)))
      else $error("Repair flags read wrong");
   a_read_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !i_cmd.mrr |=> (!o_read_valid && o_read_data == 8'h00))
      else $error("Read data without a read");
   a_test_read_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_cmd.mrr && i_cmd.addr == dmr_pkg::ADDR_TEST_IGN) |=> o_read_data == 8'h00)
      else $error("Test register read nonzero");
   a_pat_a_hidden: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_cmd.mrr && i_cmd.addr == dmr_pkg::ADDR_PAT_A) |=> o_read_data == 8'h00)
      else $error("Write-only pattern visible on read");
   a_flag_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_cmd.mrr && i_cmd.addr == dmr_pkg::ADDR_ECC_CTL)
      |=> (o_read_data[dmr_pkg::BIT_DOUBLE] == $past(flag_double)
      && o_read_data[dmr_pkg::BIT_EVENT] == $past(flag_event)))
      else $error("Error flags read wrong");
   a_clear_reads_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_cmd.mrr && i_cmd.addr == dmr_pkg::ADDR_ECC_CTL)
      |=> !o_read_data[dmr_pkg::BIT_REC_CLR])
      else $error("Record clear bit read back as one");
   a_count_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_cmd.mrr && i_cmd.addr == dmr_pkg::ADDR_ECC_CNT) |=> o_read_data == $past(event_count))
      else $error("Event counter read wrong");

   // Stored settings change only on a write to their own address
   a_test_reg_ignored: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      wr_to(i_cmd, dmr_pkg::ADDR_TEST_IGN) |=> ($stable(pattern_a) && $stable(trr_en)
      && $stable(trr_bank) && $stable(ecc_on) && $stable(err_pin_en)))
      else $error("Test register write changed a setting");
   a_trr_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      wr_to(i_cmd, dmr_pkg::ADDR_ACT_TRR)
      |=> (trr_en == $past(i_cmd.op[dmr_pkg::BIT_TRR_EN]) && trr_bank
      == $past(i_cmd.op[dmr_pkg::BIT_TRR_BANK_HI:dmr_pkg::BIT_TRR_BANK_LO])))
      else $error("Row-refresh settings not loaded");
   a_trr_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !wr_to(i_cmd, dmr_pkg::ADDR_ACT_TRR) |=> ($stable(trr_en) && $stable(trr_bank)))
      else $error("Row-refresh settings changed without write");
   a_pat_a_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !wr_to(i_cmd, dmr_pkg::ADDR_PAT_A) |=> $stable(pattern_a))
      else $error("Pattern A changed without write");
   a_ecc_on_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      wr_to(i_cmd, dmr_pkg::ADDR_ECC_CTL)
      |=> ecc_on == $past(i_cmd.op[dmr_pkg::BIT_ECC_ON]))
      else $error("Correction enable not loaded");
   a_err_pin_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      wr_to(i_cmd, dmr_pkg::ADDR_ECC_CTL)
      |=> err_pin_en == $past(i_cmd.op[dmr_pkg::BIT_ERR_PIN]))
      else $error("Error pin enable not loaded");

   // Error records
   a_event_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (ecc_on && i_ecc_event) |=> flag_event)
      else $error("Event flag not set");
   a_double_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (ecc_on && i_ecc_double) |=> flag_double)
      else $error("Double-bit flag not set");
   a_double_sticky: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (flag_double && !record_clear) |=> flag_double)
      else $error("Double-bit flag dropped without clear");
   a_off_no_record: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (!ecc_on && !flag_event && !flag_double) |=> (!flag_event && !flag_double))
      else $error("Error recorded while correction off");
   a_count_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (!(ecc_on && i_ecc_event) && !record_clear) |=> $stable(event_count))
      else $error("Event counter moved without event");
   a_pad_on: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (ecc_on && err_pin_en && (flag_event || flag_double)) |-> o_err_pad)
      else $error("Error pad silent with error recorded");
   a_pad_needs_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_err_pad |-> (flag_event || flag_double))
      else $error("Error pad driven without error");

   // Calibration return
   a_cal_capture: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state == DMR_IDLE && cal_start)
      |=> cal_stream == {$past(i_pattern_b), $past(pattern_a)})
      else $error("Calibration patterns not captured");
   a_cal_first_bit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state == DMR_IDLE && cal_start) |=> ##1 (o_cal_valid && o_cal_beat.data_mask_inversion_pin[0] == cal_stream[0]))
      else $error("Calibration did not start with bit zero");
   a_cal_stream_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state == DMR_SEND) |=> $stable(cal_stream))
      else $error("Calibration restarted during a burst");
   a_state_onehot: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $onehot(state))
      else $error("Calibration state not one-hot");
   a_dq_invert: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_cal_valid |-> ((o_cal_beat.dq ^ {16{o_cal_beat.data_mask_inversion_pin[0]}})
      == {$past(i_invert_upper), $past(i_invert_lower)}))
      else $error("Lane inversion wrong");
   a_no_bus_inv: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (o_cal_valid && $past(i_bus_inv_read_en)) |-> (o_cal_beat.dq
      == ({16{$past(cal_bit)}} ^ {$past(i_invert_upper), $past(i_invert_lower)})))
      else $error("Calibration data encoded");

   // Checker helper: a run of valid beats must be one whole burst
   logic [4:0] valid_run;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         valid_run <= 5'h00;
      end else if (o_cal_valid) begin
         valid_run <= valid_run + 5'h01;
      end else begin
         valid_run <= 5'h00;
      end
   end
   a_burst_max: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      valid_run <= 5'(dmr_pkg::BURST_BITS))
      else $error("Calibration burst too long");
   a_burst_exact: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (!o_cal_valid && valid_run != 5'h00) |-> valid_run == 5'(dmr_pkg::BURST_BITS))
      else $error("Calibration burst too short");
endmodule

// file: rtl/dmr_pkg.sv
// Constants, field layouts and carriers for the DRAM mode-register group
// Assumes a single 200 MHz command clock and decoded mode-register commands
// Notes on behaviour
// - Max-activate code reports tested limit: 001=700K down to 110=200K, 111 reserved
// - Unlimited bit set means no activate limit and max-activate code reads zero
// - Repair-resource register is read-only, one bit per bank, one when repair remains
// - Writes to test register 1E are accepted and change nothing
// - Multipurpose opcode 1000011 returns pattern A then pattern B on data lanes
// - Pattern A resets to 5A and takes any later write to its address
// - Pattern return inverts each lane whose per-lane invert bit is set
// - Upper-byte mask/inversion pin is never inverted during pattern return
// - No bus-inversion encoding is applied to calibration return data
// - Correction enable bit 7 switches on-die correction, resets to one
// - Error-pin enable bit 6, reset zero, drives error pad only while correction on
// - Record-clear bit 5 clears both flags and counter, then self-clears
// - Double-bit and event flags set on detection and hold until record clear
// - Event counter starts at zero and counts each detected event
// - Event counter saturates at its maximum instead of wrapping
package dmr_pkg;
   localparam logic [5:0] ADDR_ACT_TRR = 6'h18;
   localparam logic [5:0] ADDR_REPAIR = 6'h19;
   localparam logic [5:0] ADDR_TEST_IGN = 6'h1e;
   localparam logic [5:0] ADDR_PAT_A = 6'h20;
   localparam logic [5:0] ADDR_ECC_CTL = 6'h21;
   localparam logic [5:0] ADDR_ECC_CNT = 6'h22;

   localparam logic [7:0] PAT_A_RESET = 8'h5a;
   localparam logic [6:0] OPC_READ_CAL = 7'h43;

   localparam int BIT_TRR_EN = 7;
   localparam int BIT_TRR_BANK_HI = 6;
   localparam int BIT_TRR_BANK_LO = 4;
   localparam int BIT_UNLIMITED = 3;
   localparam int BIT_ECC_ON = 7;
   localparam int BIT_ERR_PIN = 6;
   localparam int BIT_REC_CLR = 5;
   localparam int BIT_DOUBLE = 1;
   localparam int BIT_EVENT = 0;

   localparam logic [2:0] MAC_UNKNOWN = 3'h0;
   localparam logic [2:0] MAC_RESERVED = 3'h7;
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam int BURST_BITS = 16;

   // One decoded command from the command/address decoder
   typedef struct packed {
      logic mode_register_write;
      logic mrr;
      logic multipurpose_command;
      logic [5:0] addr;
      logic [7:0] op;
   } dmr_cmd_s;

   // Per-lane calibration bits for one beat, DQ[15:0] and DATA_MASK_INVERSION_PIN[1:0]
   typedef struct packed {
      logic [1:0] data_mask_inversion_pin;
      logic [15:0] dq;
   } dmr_beat_s;
endpackage

// file: test/dmr_ctl_model.sv
// Controller model issuing decoded mode-register and calibration commands
// Assumes the register block samples the command on the rising clock edge
`timescale 1ns/1ps
module dmr_ctl_model (
   input wire logic i_clk,
   output dmr_pkg::dmr_cmd_s o_cmd
);
   initial o_cmd = '0;

   // One command per call, held over exactly one sampling edge
   task automatic issue(input logic w, input logic r, input logic m, input logic [5:0] a,
      input logic [7:0] op);
      @(posedge i_clk);
      #1;
      o_cmd = '{mode_register_write: w, mrr: r, multipurpose_command: m, addr: a, op: op};
      @(posedge i_clk);
      #1;
      // Released fields show stale inverse, not a kind copy
      o_cmd = '{mode_register_write: 1'b0, mrr: 1'b0, multipurpose_command: 1'b0, addr: ~a, op: ~op};
   endtask
endmodule

// file: test/dmr_mode_regs_test.sv
// Self-checking bench for the DRAM mode-register group
// Assumes the controller model issues every command to the block
`timescale 1ns/1ps
module dmr_mode_regs_test;
   logic i_clk, i_reset_n, i_bus_inv_read_en, i_ecc_event, i_ecc_double;
   logic [7:0] i_repair_avail, i_pattern_b, i_invert_lower, i_invert_upper, o_read_data;
   logic o_read_valid, o_cal_valid, o_correction_enable, o_targeted_row_refresh, o_err_pad;
   logic [2:0] o_target_bank_select;
   dmr_pkg::dmr_cmd_s cmd;
   dmr_pkg::dmr_beat_s o_cal_beat;
   logic [7:0] unl_read_data;
   int error_cnt = 0;
   int total_checks = 0;

   dmr_ctl_model ctl (.i_clk(i_clk), .o_cmd(cmd));
   dmr_mode_regs dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd(cmd),
      .i_repair_avail(i_repair_avail), .i_pattern_b(i_pattern_b),
      .i_invert_lower(i_invert_lower), .i_invert_upper(i_invert_upper),
      .i_bus_inv_read_en(i_bus_inv_read_en), .i_ecc_event(i_ecc_event),
      .i_ecc_double(i_ecc_double), .o_read_data(o_read_data), .o_read_valid(o_read_valid),
      .o_cal_beat(o_cal_beat), .o_cal_valid(o_cal_valid),
      .o_correction_enable(o_correction_enable),
      .o_targeted_row_refresh(o_targeted_row_refresh),
      .o_target_bank_select(o_target_bank_select), .o_err_pad(o_err_pad));
   // Second copy reports an unlimited activate count
   dmr_mode_regs #(.MAC_UNLIMITED(1'b1)) dut_unlimited (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_cmd(cmd), .i_repair_avail(i_repair_avail), .i_pattern_b(i_pattern_b),
      .i_invert_lower(i_invert_lower), .i_invert_upper(i_invert_upper),
      .i_bus_inv_read_en(i_bus_inv_read_en), .i_ecc_event(i_ecc_event),
      .i_ecc_double(i_ecc_double), .o_read_data(unl_read_data), .o_read_valid(),
      .o_cal_beat(), .o_cal_valid(), .o_correction_enable(), .o_targeted_row_refresh(),
      .o_target_bank_select(), .o_err_pad());

   task automatic give_verdict();
      $display("checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      ctl.issue(1'b0, 1'b1, 1'b0, a, 8'h00);
      chk("read valid", 18'h1, {17'h0, o_read_valid});
      chk("read data", {10'h0, exp}, {10'h0, o_read_data});
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] op);
      ctl.issue(1'b1, 1'b0, 1'b0, a, op);
   endtask

   task automatic ecc_pulses(input int n, input logic dbl);
      repeat (n) begin
         @(posedge i_clk);
         #1;
         i_ecc_event = 1'b1;
         i_ecc_double = dbl;
         @(posedge i_clk);
         #1;
         i_ecc_event = 1'b0;
         i_ecc_double = 1'b0;
      end
   endtask

   // Pattern A then B, low bit first, with lane inversion but plain mask pins
   task automatic cal_run(input logic [7:0] pa);
      logic [15:0] bits;
      int n;
      bits = {i_pattern_b, pa};
      ctl.issue(1'b0, 1'b0, 1'b1, 6'h00, {1'b0, dmr_pkg::OPC_READ_CAL});
      n = 0;
      while (o_cal_valid !== 1'b1 && n < 5) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk("cal start", 18'h1, n[17:0]);
      if (n == 5) give_verdict();
      for (int i = 0; i < 16; i++) begin
         chk("cal beat", {{2{bits[i]}}, {16{bits[i]}} ^ {i_invert_upper, i_invert_lower}},
            o_cal_beat);
         @(posedge i_clk);
         #1;
      end
      chk("cal end", 18'h0, {17'h0, o_cal_valid});
   endtask

   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   initial begin
      i_reset_n = 1'b0;
      i_ecc_event = 1'b0;
      i_ecc_double = 1'b0;
      i_repair_avail = 8'ha5;
      i_pattern_b = 8'hc3;
      i_invert_lower = 8'h0f;
      i_invert_upper = 8'h80;
      // Bus inversion on, to show calibration ignores it
      i_bus_inv_read_en = 1'b1;
      repeat (10) @(posedge i_clk);
      #1;
      i_reset_n = 1'b1;
      chk("ecc on", 18'h1, {17'h0, o_correction_enable});
      chk("trr", 18'h0, {14'h0, o_targeted_row_refresh, o_target_bank_select});
      rd(dmr_pkg::ADDR_ACT_TRR, 8'h01);
      chk("unlimited read", 18'h08, {10'h0, unl_read_data});
      wr(dmr_pkg::ADDR_ACT_TRR, 8'hd0);
      chk("trr", 18'hd, {14'h0, o_targeted_row_refresh, o_target_bank_select});
      rd(dmr_pkg::ADDR_ACT_TRR, 8'h01);
      wr(dmr_pkg::ADDR_REPAIR, 8'h00);
      rd(dmr_pkg::ADDR_REPAIR, 8'ha5);
      wr(dmr_pkg::ADDR_TEST_IGN, 8'hff);
      chk("trr", 18'hd, {14'h0, o_targeted_row_refresh, o_target_bank_select});
      rd(dmr_pkg::ADDR_ECC_CTL, 8'h80);
      cal_run(dmr_pkg::PAT_A_RESET);
      wr(dmr_pkg::ADDR_PAT_A, 8'h96);
      cal_run(8'h96);
      ecc_pulses(3, 1'b0);
      ecc_pulses(1, 1'b1);
      rd(dmr_pkg::ADDR_ECC_CTL, 8'h83);
      rd(dmr_pkg::ADDR_ECC_CNT, 8'h04);
      chk("err pad", 18'h0, {17'h0, o_err_pad});
      wr(dmr_pkg::ADDR_ECC_CTL, 8'h40);
      chk("ecc on", 18'h0, {17'h0, o_correction_enable});
      chk("err pad", 18'h0, {17'h0, o_err_pad});
      ecc_pulses(2, 1'b1);
      rd(dmr_pkg::ADDR_ECC_CNT, 8'h04);
      wr(dmr_pkg::ADDR_ECC_CTL, 8'hc0);
      chk("err pad", 18'h1, {17'h0, o_err_pad});
      wr(dmr_pkg::ADDR_ECC_CTL, 8'he0);
      rd(dmr_pkg::ADDR_ECC_CTL, 8'hc0);
      rd(dmr_pkg::ADDR_ECC_CNT, 8'h00);
      ecc_pulses(260, 1'b0);
      rd(dmr_pkg::ADDR_ECC_CNT, 8'hff);
      // Mid-run reset must restore every default
      wr(dmr_pkg::ADDR_ECC_CTL, 8'h40);
      @(posedge i_clk);
      #1;
      i_reset_n = 1'b0;
      @(posedge i_clk);
      #1;
      i_reset_n = 1'b1;
      chk("ecc on", 18'h1, {17'h0, o_correction_enable});
      chk("trr", 18'h0, {14'h0, o_targeted_row_refresh, o_target_bank_select});
      rd(dmr_pkg::ADDR_ECC_CTL, 8'h80);
      rd(dmr_pkg::ADDR_ECC_CNT, 8'h00);
      cal_run(dmr_pkg::PAT_A_RESET);
      give_verdict();
   end
endmodule
